// File: ppc_far_model.sv
// far side: key with contact chatter, chatter-free pin button and the regulator-good line
// assumes the bench moves the hold levels just after a rising edge
`timescale 1ns/1ps
module ppc_far_model (
    input  wire logic clk,               // bench clock
    input  wire logic rstn,              // async reset
    input  wire logic key_hold,          // finger on key
    input  wire logic pin_hold,          // finger on pin button
    input  wire logic reg_ok,            // rails in range
    output logic      on_key_input,      // low=pressed
    output logic      power_on_pin,      // low=pressed
    output logic      regs_in_regulation // last rail up
);
    logic [2:0] bounce_q; // chatter cycles left
    logic       key_q;    // last hold level
    // chatter restarts the debounce count, as a real contact would
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bounce_q <= 3'h0;
            key_q    <= 1'b0;
        end
        else
        begin
            key_q    <= key_hold;
            bounce_q <= (key_q != key_hold) ? 3'h5 : bounce_q - 3'(bounce_q != 3'h0);
        end
    end
    assign on_key_input       = (bounce_q != 3'h0) ? bounce_q[0] : !key_hold;
    assign power_on_pin       = !pin_hold;
    assign regs_in_regulation = reg_ok;
endmodule

// File: ppc_map.svh
// register indices, field positions, reset values and timing counts of the
// power-control block; assumes a 100 MHz bus clock and a 32.768 kHz tick
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH

// register indices; byte address is four times the index
`define PPC_IDX_RST_TIMING  8'h58
`define PPC_IDX_BTN_FAULT   8'h59
`define PPC_IDX_THRESH      8'h5A
`define PPC_IDX_STATE_REQ   8'h5B
`define PPC_IDX_IRQ_STATUS  8'h70
`define PPC_IDX_IRQ_MASK    8'h71
`define PPC_IDX_LIVE_STATUS 8'h72

// reset values
`define PPC_RST_RST_TIMING  8'h01
`define PPC_RST_BTN_FAULT   8'h80
`define PPC_RST_THRESH      8'h00
`define PPC_RST_STATE_REQ   8'h00

// field positions
`define PPC_POR_LSB         3
`define PPC_GR_LSB          6
`define PPC_PIN_DBNC_LSB    0
`define PPC_KEY_DBNC_LSB    2
`define PPC_LONG_EN_BIT     4
`define PPC_RESTART_EN_BIT  5
`define PPC_CL_EN_BIT       6
`define PPC_KEY_EN_BIT      7
`define PPC_UV_LSB          0
`define PPC_LSW_LSB         2
`define PPC_STORAGE_LOWEST_POWER_STATE_BIT        0
`define PPC_CORE_OFF_BIT    1

// clock rates and tick divider
`define PPC_CLK_HZ          100000000
`define PPC_LF_HZ           32768
`define PPC_LF_DIV          ((`PPC_CLK_HZ + `PPC_LF_HZ / 2) / `PPC_LF_HZ)

// times in microseconds, as printed
`define PPC_T_DBNC_SHORT_US 31250
`define PPC_T_DBNC_MID_US   125000
`define PPC_T_DBNC_LONG_US  750000
`define PPC_T_POR_0_US      2000
`define PPC_T_POR_2_US      4000
`define PPC_T_POR_3_US      8000
`define PPC_T_POR_4_US      16000
`define PPC_T_POR_5_US      128000
`define PPC_T_POR_6_US      256000
`define PPC_T_POR_7_US      1024000
`define PPC_T_GR_0_US       4000000
`define PPC_T_GR_1_US       8000000
`define PPC_T_GR_2_US       12000000
`define PPC_T_GR_3_US       16000000
`define PPC_T_LONG_US       4000000
`define PPC_T_RESTART_US    1000000

// least time in whole low-frequency ticks, rounded up
`define PPC_TICKS(us) (20'((64'(us) * 64'd32768 + 64'd999999) / 64'd1000000))

`endif

// File: ppc_pkg.sv
// types shared by the power-control block
// assumes ppc_map.svh carries all numeric constants
package ppc_pkg;
    // power pin press tracker, gray along idle-held-off-done
    typedef enum logic [1:0]
    {
        PPC_IDLE = 2'b00,
        PPC_HELD = 2'b01,
        PPC_OFF  = 2'b11,
        PPC_DONE = 2'b10
    } ppc_press_type;
endpackage

// File: ppc_power_control.sv
// power-control registers, push-button timing and state requests
// assumes a classic wishbone master on clk; key and pin inputs asynchronous
`timescale 1ns/1ps
`include "ppc_map.svh"

module ppc_power_control
    import ppc_pkg::*;
#(
    parameter int LF_DIV = `PPC_LF_DIV, // clk cycles per low-frequency tick
    parameter int ADR_W  = 10           // byte address width
)(
    input  wire logic             clk,                          // 100 MHz
    input  wire logic             rstn,                         // async reset
    input  wire logic             wb_cyc_i,                     // bus cycle
    input  wire logic             wb_stb_i,                     // strobe
    input  wire logic             wb_we_i,                      // write
    input  wire logic [ADR_W-1:0] wb_adr_i,                     // byte address
    input  wire logic [3:0]       wb_sel_i,                     // byte lanes
    input  wire logic [31:0]      wb_dat_i,                     // write data
    output logic      [31:0]      wb_dat_o,                     // read data
    output logic                  wb_ack_o,                     // acknowledge
    input  wire logic             on_key_input,                 // key, low=press
    input  wire logic             power_on_pin,                 // pin, low=press
    input  wire logic             power_pin_button_select,      // pin is button
    input  wire logic [2:0]       otp_reset_release_delay,      // otp delay code
    input  wire logic             regs_in_regulation,           // last reg up
    input  wire logic [2:0]       ldo_current_limit,            // ldo in limit
    input  wire logic             in_regs_disable,              // regs-off state
    output logic                  processor_reset_out,          // high=released
    output logic                  global_reset_req,             // pulse
    output logic                  long_press_off_req,           // pulse
    output logic                  restart_req,                  // pulse
    output logic      [2:0]       ldo_shutdown,                 // ldo forced off
    output logic                  storage_lowest_power_state_state_request,           // level
    output logic                  core_off_request,             // level
    output logic      [1:0]       undervoltage_threshold,       // uv select
    output logic      [1:0]       low_system_warning_threshold, // warn select
    output logic                  irq                           // level
);

    // elaboration guard on parameters
    if (LF_DIV < 2 || LF_DIV > 65536 || ADR_W < 10)
    begin : g_bad_param
        $error("ppc_power_control: unsupported parameter values");
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // falling edge length depends on code, rising is always short
    function automatic logic [19:0] dbnc_len(input logic [1:0] code, input logic fall);
        if (!fall || !code[1])
            return `PPC_TICKS(`PPC_T_DBNC_SHORT_US);
        else if (!code[0])
            return `PPC_TICKS(`PPC_T_DBNC_MID_US);
        else
            return `PPC_TICKS(`PPC_T_DBNC_LONG_US);
    endfunction

    // reset release delay; undocumented code 001 taken as 2 ms
    function automatic logic [19:0] por_len(input logic [2:0] code);
        case (code)
            3'h2:    return `PPC_TICKS(`PPC_T_POR_2_US);
            3'h3:    return `PPC_TICKS(`PPC_T_POR_3_US);
            3'h4:    return `PPC_TICKS(`PPC_T_POR_4_US);
            3'h5:    return `PPC_TICKS(`PPC_T_POR_5_US);
            3'h6:    return `PPC_TICKS(`PPC_T_POR_6_US);
            3'h7:    return `PPC_TICKS(`PPC_T_POR_7_US);
            default: return `PPC_TICKS(`PPC_T_POR_0_US);
        endcase
    endfunction

    // global reset hold time
    function automatic logic [19:0] gr_len(input logic [1:0] code);
        case (code)
            2'h1:    return `PPC_TICKS(`PPC_T_GR_1_US);
            2'h2:    return `PPC_TICKS(`PPC_T_GR_2_US);
            2'h3:    return `PPC_TICKS(`PPC_T_GR_3_US);
            default: return `PPC_TICKS(`PPC_T_GR_0_US);
        endcase
    endfunction

    logic [7:0]    rtc_q;      // reset timing control
    logic [7:0]    bfc_q;      // button and fault control
    logic [7:0]    thr_q;      // threshold select
    logic [7:0]    req_q;      // state request
    logic [5:0]    ist_q;      // sticky event status
    logic [5:0]    imk_q;      // event mask
    logic          loaded_q;   // otp delay code taken
    logic          ack_q;      // bus acknowledge
    logic [31:0]   dat_q;      // bus read data
    logic [15:0]   div_q;      // tick divider
    logic          tick_q;     // one-cycle tick
    logic [1:0]    s1_q;       // sync stage one, {pin,key}
    logic [1:0]    s2_q;       // sync stage two
    logic [1:0]    deb_q;      // debounced levels
    logic [1:0]    deb_prev_q; // debounced, one cycle back
    logic [14:0]   dcnt_q [2]; // debounce counters
    logic [19:0]   khold_q;    // key hold ticks
    logic          kfired_q;   // key hold expired this press
    logic [19:0]   pcnt_q;     // pin press ticks
    ppc_press_type pst_q;      // pin press tracker
    logic [19:0]   por_q;      // reset release ticks
    logic [5:0]    ev;         // events this cycle
    logic          acc;        // new bus access
    logic          wr;         // register write
    logic [7:0]    idx;        // register index
    logic [7:0]    rd;         // read mux
    logic [7:0]    wd;         // write byte

    assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr  = acc & wb_we_i & wb_sel_i[0];
    assign idx = wb_adr_i[9:2];
    assign wd  = wb_dat_i[7:0];
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // read mux; unmapped indices read zero
    always_comb
    begin
        case (idx)
            `PPC_IDX_RST_TIMING:  rd = rtc_q;
            `PPC_IDX_BTN_FAULT:   rd = bfc_q;
            `PPC_IDX_THRESH:      rd = thr_q;
            `PPC_IDX_STATE_REQ:   rd = req_q;
            `PPC_IDX_IRQ_STATUS:  rd = {2'h0, ist_q};
            `PPC_IDX_IRQ_MASK:    rd = {2'h0, imk_q};
            `PPC_IDX_LIVE_STATUS: rd = {2'h0, pst_q, deb_q, in_regs_disable,
                                        processor_reset_out};
            default:              rd = 8'h00;
        endcase
    end

    // bus answer one cycle after the request, dropped next cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= acc;
            if (acc && !wb_we_i)
                dat_q <= {24'h00_0000, rd};
        end
    end

    // control registers; rw1s fields can only gain ones until reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rtc_q    <= `PPC_RST_RST_TIMING;
            bfc_q    <= `PPC_RST_BTN_FAULT;
            thr_q    <= `PPC_RST_THRESH;
            req_q    <= `PPC_RST_STATE_REQ;
            imk_q    <= 6'h00;
            loaded_q <= 1'b0;
        end
        else
        begin
            loaded_q <= 1'b1;
            // strap caught on the first edge after release
            if (!loaded_q)
                rtc_q[`PPC_POR_LSB +: 3] <= otp_reset_release_delay;
            else if (wr && idx == `PPC_IDX_RST_TIMING)
                rtc_q <= {rtc_q[7:3] | wd[7:3], wd[2:0]};
            if (wr && idx == `PPC_IDX_BTN_FAULT)
                bfc_q <= wd;
            if (wr && idx == `PPC_IDX_THRESH)
                thr_q <= {4'h0, wd[3:2], thr_q[1:0] | wd[1:0]};
            if (wr && idx == `PPC_IDX_STATE_REQ)
                req_q <= {6'h00, wd[1:0]};
            if (wr && idx == `PPC_IDX_IRQ_MASK)
                imk_q <= wd[5:0];
        end
    end

    assign undervoltage_threshold       = thr_q[`PPC_UV_LSB +: 2];
    assign low_system_warning_threshold = thr_q[`PPC_LSW_LSB +: 2];
    assign storage_lowest_power_state_state_request           = req_q[`PPC_STORAGE_LOWEST_POWER_STATE_BIT];

    // core-off only takes effect once regulators are disabled
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            core_off_request <= 1'b0;
        else
            core_off_request <= req_q[`PPC_CORE_OFF_BIT] & in_regs_disable;
    end

    // sticky status, write one clears; a new event beats the clear
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ist_q <= 6'h00;
        else if (wr && idx == `PPC_IDX_IRQ_STATUS)
            ist_q <= (ist_q & ~wd[5:0]) | ev;
        else
            ist_q <= ist_q | ev;
    end

    assign irq = |(ist_q & imk_q);

    // low-frequency tick from the bus clock
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_q  <= 16'h0000;
            tick_q <= 1'b0;
        end
        else if (div_q == 16'(LF_DIV - 1))
        begin
            div_q  <= 16'h0000;
            tick_q <= 1'b1;
        end
        else
        begin
            div_q  <= div_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    // two-stage synchroniser, released buttons read high
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_q <= 2'h3;
            s2_q <= 2'h3;
        end
        else
        begin
            s1_q <= {power_on_pin, on_key_input};
            s2_q <= s1_q;
        end
    end

    // debounce: count ticks while raw differs, any return restarts it
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            deb_q      <= 2'h3;
            deb_prev_q <= 2'h3;
            dcnt_q[0]  <= 15'h0000;
            dcnt_q[1]  <= 15'h0000;
        end
        else
        begin
            deb_prev_q <= deb_q;
            for (int i = 0; i < 2; i++)
            begin
                if (i == 1 && !power_pin_button_select)
                begin
                    deb_q[i]  <= s2_q[i]; // level mode, no debounce
                    dcnt_q[i] <= 15'h0000;
                end
                else if (s2_q[i] == deb_q[i])
                    dcnt_q[i] <= 15'h0000;
                else if (tick_q)
                begin
                    // index 0 is the key, whose code sits above the pin code
                    if (20'(dcnt_q[i]) + 20'h1 >= dbnc_len(bfc_q[((i == 0) ?
                        `PPC_KEY_DBNC_LSB : `PPC_PIN_DBNC_LSB) +: 2], deb_q[i]))
                    begin
                        deb_q[i]  <= s2_q[i];
                        dcnt_q[i] <= 15'h0000;
                    end
                    else
                        dcnt_q[i] <= dcnt_q[i] + 15'h0001;
                end
            end
        end
    end

    // key hold: one global reset per press, blocked by key enable
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            khold_q          <= 20'h00000;
            kfired_q         <= 1'b0;
            global_reset_req <= 1'b0;
        end
        else
        begin
            global_reset_req <= 1'b0;
            if (deb_q[0])
            begin
                khold_q  <= 20'h00000;
                kfired_q <= 1'b0;
            end
            else if (tick_q && !kfired_q)
            begin
                if (khold_q + 20'h1 >= gr_len(rtc_q[`PPC_GR_LSB +: 2]))
                begin
                    kfired_q         <= 1'b1;
                    global_reset_req <= bfc_q[`PPC_KEY_EN_BIT];
                end
                else
                    khold_q <= khold_q + 20'h1;
            end
        end
    end

    // power pin press tracker: long press, then restart one second on
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pst_q              <= PPC_IDLE;
            pcnt_q             <= 20'h00000;
            long_press_off_req <= 1'b0;
            restart_req        <= 1'b0;
        end
        else
        begin
            long_press_off_req <= 1'b0;
            restart_req        <= 1'b0;
            if (deb_q[1] || !power_pin_button_select)
            begin
                pst_q  <= PPC_IDLE; // release ends any press
                pcnt_q <= 20'h00000;
            end
            else
            begin
                case (pst_q)
                    PPC_IDLE:
                        pst_q <= PPC_HELD;
                    PPC_HELD:
                        if (tick_q)
                        begin
                            if (pcnt_q + 20'h1 >= `PPC_TICKS(`PPC_T_LONG_US))
                            begin
                                pcnt_q <= 20'h00000;
                                // disabled long press raises no request, tracker goes to done
                                if (bfc_q[`PPC_LONG_EN_BIT])
                                begin
                                    long_press_off_req <= 1'b1;
                                    pst_q              <= PPC_OFF;
                                end
                                else
                                    pst_q <= PPC_DONE;
                            end
                            else
                                pcnt_q <= pcnt_q + 20'h1;
                        end
                    PPC_OFF:
                        if (tick_q && bfc_q[`PPC_RESTART_EN_BIT])
                        begin
                            if (pcnt_q + 20'h1 >= `PPC_TICKS(`PPC_T_RESTART_US))
                            begin
                                restart_req <= 1'b1;
                                pst_q       <= PPC_DONE;
                            end
                            else
                                pcnt_q <= pcnt_q + 20'h1;
                        end
                    PPC_DONE:
                        pst_q <= PPC_DONE;
                    default:
                        pst_q <= PPC_IDLE;
                endcase
            end
        end
    end

    // ldo off on limit fault while enabled; clearing enable restores
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ldo_shutdown <= 3'h0;
        else if (bfc_q[`PPC_CL_EN_BIT])
            ldo_shutdown <= ldo_shutdown | ldo_current_limit;
        else
            ldo_shutdown <= 3'h0;
    end

    // processor reset held until regulation lasts the coded delay
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            por_q               <= 20'h00000;
            processor_reset_out <= 1'b0;
        end
        else if (!regs_in_regulation)
        begin
            por_q               <= 20'h00000;
            processor_reset_out <= 1'b0;
        end
        else if (tick_q && !processor_reset_out)
        begin
            if (por_q + 20'h1 >= por_len(rtc_q[`PPC_POR_LSB +: 3]))
                processor_reset_out <= 1'b1;
            else
                por_q <= por_q + 20'h1;
        end
    end

    // event vector for the sticky status
    assign ev = {|(ldo_current_limit & ~ldo_shutdown) & bfc_q[`PPC_CL_EN_BIT],
                 restart_req, long_press_off_req, global_reset_req,
                 deb_prev_q[1] & ~deb_q[1], deb_prev_q[0] & ~deb_q[0]};

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");
    a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_reset_drop: assert property (!regs_in_regulation |=> !processor_reset_out)
        else $error("processor reset released without regulation");
    a_reset_delay: assert property ($rose(processor_reset_out) |->
        $past(por_q) + 20'h1 >= por_len($past(rtc_q[5:3])))
        else $error("processor reset released early");
    a_key_block: assert property (global_reset_req |-> $past(bfc_q[7]))
        else $error("key reset while key turn-off disabled");
    a_key_hold: assert property (global_reset_req |->
        $past(khold_q) + 20'h1 >= gr_len($past(rtc_q[7:6])))
        else $error("global reset before hold time");
    a_long_enable: assert property (long_press_off_req |-> $past(bfc_q[4]))
        else $error("long press acted while disabled");
    a_restart_path: assert property (restart_req |->
        $past(pst_q) == PPC_OFF && $past(bfc_q[5]))
        else $error("restart without prior long press");
    a_ldo_trip: assert property (bfc_q[6] && |ldo_current_limit |=>
        (ldo_shutdown & $past(ldo_current_limit)) == $past(ldo_current_limit))
        else $error("faulting ldo left on");
    a_ldo_keep: assert property (!bfc_q[6] |=> ldo_shutdown == 3'h0)
        else $error("ldo off with shutdown disabled");
    a_key_debounce: assert property ($changed(deb_q[0]) |->
        $past(s2_q[0]) != $past(deb_q[0]) && $past(tick_q))
        else $error("key level changed without a settled input");
    a_pin_debounce: assert property (power_pin_button_select && $fell(deb_q[1]) |->
        $past(dcnt_q[1]) + 15'h1 >= 15'(dbnc_len($past(bfc_q[1:0]), 1'b1)))
        else $error("pin press accepted before debounce time");
    a_uv_sticky: assert property (!$fell(undervoltage_threshold[0]) &&
        !$fell(undervoltage_threshold[1]))
        else $error("undervoltage select bit cleared");
    a_warn_write: assert property (wr && idx == 8'h5A |=>
        low_system_warning_threshold == $past(wd[3:2]))
        else $error("warning select not written");
    a_storage_lowest_power_state_req: assert property (wr && idx == 8'h5B && wd[0] |=> storage_lowest_power_state_state_request)
        else $error("storage_lowest_power_state request not raised");
    a_core_off: assert property (core_off_request |-> $past(in_regs_disable))
        else $error("core-off outside regs-disable");

    c_global_reset: cover property (global_reset_req);
    c_restart:      cover property (restart_req);
    c_ldo_off:      cover property ($rose(ldo_shutdown[0]));
    c_storage_lowest_power_state:         cover property ($rose(storage_lowest_power_state_state_request));

endmodule

// File: tb_ppc_power_control.sv
// self-checking bench for the power-control block
// assumes the far-side model; ticks shortened to every 2 clocks
`timescale 1ns/1ps
module tb_ppc_power_control;
    typedef struct packed {logic w; logic [9:0] a; logic [7:0] d; logic [7:0] e;} ppc_row_type;
    logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, ack, key_hold = 0, pin_hold = 0;
    logic reg_ok = 1, regs_off = 0, btn = 1, rel, storage_lowest_power_state, coff, irq, key_n, pin_n, reg_up;
    logic [9:0]  adr = '0;
    logic [31:0] dat = '0, rd, dat_o;
    logic [2:0]  ldo_lim = '0, ldo_off, otp = '0;
    logic [1:0]  uv, lsw;
    int n_mismatch = 0, checks = 0;
    ppc_row_type rows [11] = '{'{0,10'h160,8'h00,8'h01}, '{0,10'h164,8'h00,8'h80},
        '{0,10'h168,8'h00,8'h00}, '{0,10'h16C,8'h00,8'h00}, '{1,10'h160,8'hC1,8'hC1},
        '{1,10'h160,8'h00,8'hC0}, '{1,10'h168,8'h0D,8'h0D}, '{1,10'h168,8'h00,8'h01},
        '{1,10'h164,8'h3F,8'h3F}, '{1,10'h164,8'h02,8'h02}, '{1,10'h100,8'hFF,8'h00}};
    ppc_far_model u_far (.clk(clk), .rstn(rstn), .key_hold(key_hold), .pin_hold(pin_hold),
        .reg_ok(reg_ok), .on_key_input(key_n), .power_on_pin(pin_n), .regs_in_regulation(reg_up));
    ppc_power_control #(.LF_DIV(2)) u_dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .on_key_input(key_n), .power_on_pin(pin_n),
        .power_pin_button_select(btn), .otp_reset_release_delay(otp),
        .regs_in_regulation(reg_up), .ldo_current_limit(ldo_lim), .in_regs_disable(regs_off),
        .processor_reset_out(rel), .global_reset_req(), .long_press_off_req(),
        .restart_req(), .ldo_shutdown(ldo_off), .storage_lowest_power_state_state_request(storage_lowest_power_state),
        .core_off_request(coff), .undervoltage_threshold(uv),
        .low_system_warning_threshold(lsw), .irq(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic cycle; waits for ack, never assumes its latency
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        rd = dat_o;
        n_mismatch += int'(n >= 20);
        {cyc, stb} <= 2'b00;
    endtask
    task automatic test_done;
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial forever #5 clk = ~clk;
    initial
    begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        test_done;
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1;
        repeat (100) @(posedge clk);
        chk(rel, 0);
        repeat (60) @(posedge clk);
        chk(rel, 1);
        reg_ok <= 0;
        repeat (3) @(posedge clk);
        chk(rel, 0);
        reg_ok <= 1;
        // table of register cases, each read back
        foreach (rows[i])
        begin
            if (rows[i].w)
                bus(1, rows[i].a, 32'(rows[i].d));
            bus(0, rows[i].a, 0);
            chk(rd, 32'(rows[i].e));
        end
        chk({uv, lsw}, 4'h4);
        ldo_lim <= 3'h2;
        repeat (3) @(posedge clk);
        chk(ldo_off, 0);
        bus(1, 10'h164, 32'h42);
        repeat (2) @(posedge clk);
        chk({ldo_off, irq}, 4'h4);
        bus(1, 10'h1C4, 32'h20);
        chk(irq, 1);
        ldo_lim <= 3'h0;
        bus(1, 10'h164, 32'h02);
        bus(1, 10'h1C0, 32'h20);
        repeat (2) @(posedge clk);
        chk({ldo_off, irq}, 0);
        // key press with chatter, then pin with the 125 ms fall code
        key_hold <= 1;
        repeat (1900) @(posedge clk);
        bus(0, 10'h1C8, 0);
        chk(rd[3:2], 2'h3);
        repeat (400) @(posedge clk);
        bus(0, 10'h1C8, 0);
        chk(rd[3:2], 2'h2);
        key_hold <= 0;
        pin_hold <= 1;
        repeat (8000) @(posedge clk);
        bus(0, 10'h1C8, 0);
        chk(rd[3:2], 2'h3);
        repeat (500) @(posedge clk);
        bus(0, 10'h1C8, 0);
        chk(rd[3:2], 2'h1);
        pin_hold <= 0;
        repeat (2300) @(posedge clk);
        bus(0, 10'h1C8, 0);
        chk(rd[3:2], 2'h3);
        // one debounced press each, no hold event, ldo trip cleared
        bus(0, 10'h1C0, 0);
        chk(rd, 32'h03);
        bus(1, 10'h16C, 32'h01);
        chk(storage_lowest_power_state, 1);
        bus(1, 10'h16C, 32'h02);
        chk({storage_lowest_power_state, coff}, 0);
        regs_off <= 1;
        repeat (3) @(posedge clk);
        chk(coff, 1);
        // level mode: pin follows its synchronised level, no debounce
        btn <= 0;
        pin_hold <= 1;
        repeat (4) @(posedge clk);
        bus(0, 10'h1C8, 0);
        chk(rd[3:2], 2'h1);
        pin_hold <= 0;
        repeat (4) @(posedge clk);
        btn <= 1;
        // mid-run reset with a new strap code, 4 ms release delay
        otp <= 3'h2;
        rstn <= 0;
        @(posedge clk);
        chk({storage_lowest_power_state, coff, rel, ldo_off, irq, uv, lsw}, 0);
        rstn <= 1;
        bus(0, 10'h160, 0);
        chk(rd, 32'h11);
        bus(0, 10'h164, 0);
        chk(rd, 32'h80);
        repeat (190) @(posedge clk);
        chk(rel, 0);
        repeat (90) @(posedge clk);
        chk(rel, 1);
        test_done;
    end
endmodule
